// File: pkg/supervisor_pkg.sv
`default_nettype none
package supervisor_pkg;
   // service register field layout
   localparam int WIN_MSB = 7;
   localparam int WIN_LSB = 6;
   localparam int KEY_MSB = 5;
   localparam int KEY_LSB = 1;
   localparam int CM_BIT  = 0;
   localparam logic [4:0] SVC_KEY = 5'h0c;
   // values taken when reset is released
   localparam logic [1:0] WIN_RESET = 2'h3;
   localparam logic       CM_RESET  = 1'h1;
   // config option bit that enables the supervisor when low
   localparam int CFG_ENABLE_BIT = 2;
   // window limits in instruction cycles
   localparam logic [15:0] LOWER_LIMIT = 16'h0800;
   localparam logic [15:0] UPPER_M1_8K  = 16'h1fff;
   localparam logic [15:0] UPPER_M1_16K = 16'h3fff;
   localparam logic [15:0] UPPER_M1_32K = 16'h7fff;
   localparam logic [15:0] UPPER_M1_64K = 16'hffff;
   // fault pin held low for one more than this many cycles after sensing
   localparam logic [4:0] FAULT_HOLD_M1 = 5'h0f;
   // clock monitor: no oscillator edge for this long means too slow
   localparam int CLK_MHZ       = 100;
   localparam int CM_TIMEOUT_US = 1000;
   localparam int CM_CYCLES     = CM_TIMEOUT_US * CLK_MHZ;
   typedef enum logic [3:0]
   {
      ST_RUN   = 4'b0001,
      ST_DRIVE = 4'b0010,
      ST_HOLD  = 4'b0100,
      ST_WAIT  = 4'b1000
   } fault_state_t;
endpackage
`default_nettype wire

// File: src/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
   parameter int WIDTH = 2
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             ce_i,
   input  wire logic [WIDTH-1:0] d_i,
   output logic      [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta;

   // two stages; only the second stage reads the first
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         meta <= '0;
         q_o  <= '0;
      end
      else if (ce_i)
      begin
         meta <= d_i;
         q_o  <= meta;
      end
   end
endmodule
`default_nettype wire

// File: src/clock_rate_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module clock_rate_monitor #(
   parameter int CM_W     = 17,
   parameter int TIMEOUT  = supervisor_pkg::CM_CYCLES
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic osc_i,
   output logic      tick_o,
   output logic      slow_o
);
   logic            osc_prev;
   logic [CM_W-1:0] gap;
   wire             osc_edge = osc_i ^ osc_prev;
   wire             gap_full = (gap == CM_W'(TIMEOUT - 1));

   // instruction tick on each rising oscillator edge
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         osc_prev <= 1'h0;
         tick_o   <= 1'h0;
      end
      else if (ce_i)
      begin
         osc_prev <= osc_i;
         tick_o   <= osc_i & ~osc_prev;
      end
   end

   // gap between edges; a dead oscillator saturates and stays slow
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         gap    <= '0;
         slow_o <= 1'h0;
      end
      else if (ce_i)
      begin
         if (osc_edge)
         begin
            gap    <= '0;
            slow_o <= 1'h0;
         end
         else if (gap_full)
            slow_o <= 1'h1;
         else
            gap <= gap + CM_W'(1);
      end
   end
endmodule
`default_nettype wire

// File: src/service_window_timer_clkmon.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// - service register: window select 7:6, key 5:1, monitor enable 0.
// - a write is a valid service only with key 01100.
// - lower window limit is 2048 cycles for every upper limit.
// - window select 00/01/10/11 gives 8k/16k/32k/64k upper limit.
// - monitor enable bit 0 disables, 1 enables frequency check.
// - supervisor and monitor detect nothing while reset is held.
// - after reset: armed, maximum window, clock monitor enabled.
// - config bit 2 low activates supervisor and its fault pin.
// - only first keyed write after reset loads window and monitor.
// - later writes compare bits 7:1; any mismatch is an error.
// - no valid service before upper limit gives a fault.
// - a service after the first, before 2048 cycles elapse, is an error.
// - fault pin active low, only weak pullup while inactive.
// - drive pin low, hold 16-32 cycles after sensed low, release.
// - window timing restarts when the pin returns high.
// - service writes during an active fault are ignored.
// - slow clock holds pin low; release 16-32 cycles after recovery.
// - monitor accepts 10 kHz and above, rejects below 10 Hz.
// - a dead or slow oscillator after reset gives continual error.
// - reading the service register returns zeros in the key field.
// - supervisor inhibited in either stop mode.
// - key mismatch on the first service is an error.
module service_window_timer_clkmon #(
   parameter int CM_TIMEOUT = supervisor_pkg::CM_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   input  wire logic [7:0] config_option_reg_i,
   input  wire logic       stop_mode_i,
   input  wire logic       oscillator_input_pin_i,
   input  wire logic       svc_wr_i,
   input  wire logic [7:0] svc_wdata_i,
   output logic      [7:0] svc_rdata_o,
   input  wire logic       fault_port_pin_i,
   output logic            fault_port_pin_o,
   output logic            fault_port_pin_oe_o
);
   supervisor_pkg::fault_state_t state;
   supervisor_pkg::fault_state_t next_state;
   logic [1:0]  win_sel;
   logic        cm_en;
   logic        configured;
   logic [15:0] cnt;
   logic [15:0] next_cnt;
   logic [4:0]  hold_cnt;
   logic [4:0]  next_hold_cnt;
   logic [1:0]  pins_s;
   logic        tick_raw;
   logic        slow;

   // both pins are asynchronous to clk_i
   pin_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .ce_i  (ce_i),
      .d_i   ({oscillator_input_pin_i, fault_port_pin_i}),
      .q_o   (pins_s)
   );

   // edge gap timeout sits between 50 us and 50 ms half periods
   clock_rate_monitor #(
      .CM_W    (17),
      .TIMEOUT (CM_TIMEOUT)
   ) u_clkmon (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .ce_i   (ce_i),
      .osc_i  (pins_s[1]),
      .tick_o (tick_raw),
      .slow_o (slow)
   );

   // qualifiers
   wire active   = ~config_option_reg_i[supervisor_pkg::CFG_ENABLE_BIT];
   wire sup_run  = active & ~stop_mode_i;
   wire tick     = ce_i & tick_raw;
   wire pin_high = pins_s[0];
   wire cm_err   = active & cm_en & slow;
   wire in_run   = (state == supervisor_pkg::ST_RUN);

   // service decode; writes outside RUN fall on the floor
   wire [4:0] wr_key = svc_wdata_i[supervisor_pkg::KEY_MSB:
                                   supervisor_pkg::KEY_LSB];
   wire [1:0] wr_win = svc_wdata_i[supervisor_pkg::WIN_MSB:
                                   supervisor_pkg::WIN_LSB];
   wire       wr_cm  = svc_wdata_i[supervisor_pkg::CM_BIT];
   wire       key_ok = (wr_key == supervisor_pkg::SVC_KEY);
   wire       win_ok = (wr_win == win_sel);
   wire       svc    = ce_i & svc_wr_i & in_run & sup_run;
   // later writes must match window and key, bits 7:1
   wire       svc_valid = key_ok & (~configured | win_ok);
   wire       early     = configured & (cnt < supervisor_pkg::LOWER_LIMIT);
   wire       svc_good  = svc & svc_valid & ~early;
   wire       svc_bad   = svc & ~(svc_valid & ~early);

   // upper limit select
   wire [15:0] upper_m1 =
      (win_sel == 2'h0) ? supervisor_pkg::UPPER_M1_8K  :
      (win_sel == 2'h1) ? supervisor_pkg::UPPER_M1_16K :
      (win_sel == 2'h2) ? supervisor_pkg::UPPER_M1_32K :
                          supervisor_pkg::UPPER_M1_64K;
   // a service landing on the last tick still counts as in time
   wire late = in_run & sup_run & tick & (cnt == upper_m1) & ~svc_good;
   wire trip = in_run & (svc_bad | late | cm_err);
   wire hold_done = tick & (hold_cnt == supervisor_pkg::FAULT_HOLD_M1);

   // fault sequencing on the pin
   always_comb
   begin
      next_state    = state;
      next_hold_cnt = hold_cnt;
      unique case (state)
         supervisor_pkg::ST_RUN:
         begin
            if (trip)
               next_state = supervisor_pkg::ST_DRIVE;
         end
         supervisor_pkg::ST_DRIVE:
         begin
            next_hold_cnt = 5'h00;
            if (~pin_high)
               next_state = supervisor_pkg::ST_HOLD;
         end
         supervisor_pkg::ST_HOLD:
         begin
            if (cm_err)
               next_hold_cnt = 5'h00;
            else if (hold_done)
               next_state = supervisor_pkg::ST_WAIT;
            else if (tick)
               next_hold_cnt = hold_cnt + 5'h01;
         end
         supervisor_pkg::ST_WAIT:
         begin
            if (cm_err)
               next_state = supervisor_pkg::ST_DRIVE;
            else if (pin_high)
               next_state = supervisor_pkg::ST_RUN;
         end
      endcase
   end

   // window counter: one step per instruction cycle
   always_comb
   begin
      next_cnt = cnt;
      if (state == supervisor_pkg::ST_WAIT)
         next_cnt = 16'h0000;
      else if (svc_good)
         next_cnt = 16'h0000;
      else if (in_run & sup_run & tick)
         next_cnt = cnt + 16'h0001;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state    <= supervisor_pkg::ST_RUN;
         cnt      <= 16'h0000;
         hold_cnt <= 5'h00;
      end
      else if (ce_i)
      begin
         state    <= next_state;
         cnt      <= next_cnt;
         hold_cnt <= next_hold_cnt;
      end
   end

   // first keyed write locks the settings until the next reset
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         win_sel    <= supervisor_pkg::WIN_RESET;
         cm_en      <= supervisor_pkg::CM_RESET;
         configured <= 1'h0;
      end
      else if (svc & key_ok & ~configured)
      begin
         win_sel    <= wr_win;
         cm_en      <= wr_cm;
         configured <= 1'h1;
      end
   end

   // pin drive and readback; pullup is outside, so data is always low
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         fault_port_pin_o    <= 1'h0;
         fault_port_pin_oe_o <= 1'h0;
         svc_rdata_o         <= 8'h00;
      end
      else if (ce_i)
      begin
         fault_port_pin_o    <= 1'h0;
         fault_port_pin_oe_o <= active &
            ((next_state == supervisor_pkg::ST_DRIVE) |
             (next_state == supervisor_pkg::ST_HOLD));
         svc_rdata_o         <= {win_sel, 5'h00, cm_en};
      end
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   wire driving = (state == supervisor_pkg::ST_DRIVE) |
                  (state == supervisor_pkg::ST_HOLD);

   property p_key_reads_zero;
      svc_rdata_o[5:1] == 5'h00;
   endproperty
   a_key_reads_zero: assert property (p_key_reads_zero)
      else $error("key field visible on read");

   property p_early_service;
      svc & configured & svc_valid & (cnt < 16'h0800)
         |=> state == supervisor_pkg::ST_DRIVE;
   endproperty
   a_early_service: assert property (p_early_service)
      else $error("early service not flagged");

   property p_late_service;
      in_run & sup_run & tick & (cnt == upper_m1) & ~svc_wr_i
         |=> state == supervisor_pkg::ST_DRIVE;
   endproperty
   a_late_service: assert property (p_late_service)
      else $error("expired window not flagged");

   property p_settings_locked;
      configured |=> $stable(win_sel) && $stable(cm_en);
   endproperty
   a_settings_locked: assert property (p_settings_locked)
      else $error("settings changed after first service");

   property p_first_load;
      svc & ~configured & (svc_wdata_i[5:1] == 5'h0c)
         |=> configured && (win_sel == $past(svc_wdata_i[7:6]))
             && (cm_en == $past(svc_wdata_i[0]));
   endproperty
   a_first_load: assert property (p_first_load)
      else $error("first service did not load settings");

   property p_mismatch;
      svc & configured & (svc_wdata_i[7:1] != {win_sel, 5'h0c})
         |=> state == supervisor_pkg::ST_DRIVE;
   endproperty
   a_mismatch: assert property (p_mismatch)
      else $error("mismatched service not flagged");

   property p_first_bad_key;
      svc & ~configured & (svc_wdata_i[5:1] != 5'h0c)
         |=> state == supervisor_pkg::ST_DRIVE ##0 !configured;
   endproperty
   a_first_bad_key: assert property (p_first_bad_key)
      else $error("bad first key not flagged");

   property p_drive_tracks;
      ##1 fault_port_pin_oe_o == (active & driving);
   endproperty
   a_drive_tracks: assert property (p_drive_tracks)
      else $error("pin drive does not follow fault state");

   property p_restart;
      ce_i & (state == supervisor_pkg::ST_WAIT) & pin_high & ~cm_err
         |=> in_run && (cnt == 16'h0000);
   endproperty
   a_restart: assert property (p_restart)
      else $error("window did not restart on release");

   property p_ignore_in_fault;
      svc_wr_i & ~in_run |=> $stable(configured) && $stable(win_sel);
   endproperty
   a_ignore_in_fault: assert property (p_ignore_in_fault)
      else $error("service accepted during fault");

   property p_hold_length;
      ce_i & (state == supervisor_pkg::ST_HOLD) & hold_done & ~cm_err
         |=> (state == supervisor_pkg::ST_WAIT) && !fault_port_pin_oe_o;
   endproperty
   a_hold_length: assert property (p_hold_length)
      else $error("hold did not end after sixteen cycles");

   property p_stop_inhibit;
      in_run & ~sup_run & ~cm_err |=> in_run && $stable(cnt);
   endproperty
   a_stop_inhibit: assert property (p_stop_inhibit)
      else $error("supervisor ran while inhibited");

   c_first_service: cover property (svc & key_ok & ~configured);
   c_good_service:  cover property (svc_good & configured);
   c_fault_cycle:   cover property (trip ##[1:200] state == supervisor_pkg::ST_WAIT);
   c_clock_fault:   cover property (cm_err & in_run);
endmodule
`default_nettype wire

// File: tb/fault_pin_osc_model.sv
`timescale 1ns/10ps
`default_nettype none
module fault_pin_osc_model
(
   input  wire logic clk_i,
   input  wire logic run_i,
   input  wire logic oe_i,
   output logic      osc_o,
   output logic      pin_o
);
   logic [1:0] div  = 2'h0;
   logic [1:0] fall = 2'h0;

   initial osc_o = 1'b0;

   // instruction clock stands still while stopped; period of four clocks
   // plain always: osc_o also takes its start value in the initial block
   always @(posedge clk_i)
   begin
      if (run_i)
      begin
         div   <= div + 2'h1;
         osc_o <= div[0] ? ~osc_o : osc_o;
      end
   end

   // slow fall models the pin load, so sensing low takes a while
   always @(posedge clk_i)
      fall <= {fall[0], oe_i};

   // weak pullup wins whenever nobody pulls low
   assign pin_o = (oe_i && fall[1]) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: tb/service_window_timer_clkmon_tb.sv
`timescale 1ns/10ps
`default_nettype none
module service_window_timer_clkmon_tb;
   logic       clk_i     = 1'b0;
   logic       rst_i     = 1'b1;
   logic       ce_i      = 1'b1;
   logic [7:0] cfg       = 8'h00;
   logic       stop_mode = 1'b0;
   logic       run       = 1'b1;
   logic       svc_wr    = 1'b0;
   logic [7:0] svc_wdata = 8'h00;
   logic [7:0] rdata;
   logic       osc;
   logic       pin;
   logic       pin_d;
   logic       oe;
   logic       hi;
   logic [7:0] bad [2]   = '{8'h1b, 8'h59};
   int         fail_count = 0;
   int         n_checks   = 0;
   int         ticks      = 0;
   int         cyc        = 0;

   // small monitor timeout keeps the dead-clock case short
   service_window_timer_clkmon #(.CM_TIMEOUT(200))
      service_window_timer_clkmon_inst (
      .clk_i                  (clk_i),
      .rst_i                  (rst_i),
      .ce_i                   (ce_i),
      .config_option_reg_i    (cfg),
      .stop_mode_i            (stop_mode),
      .oscillator_input_pin_i (osc),
      .svc_wr_i               (svc_wr),
      .svc_wdata_i            (svc_wdata),
      .svc_rdata_o            (rdata),
      .fault_port_pin_i       (pin),
      .fault_port_pin_o       (pin_d),
      .fault_port_pin_oe_o    (oe)
   );

   fault_pin_osc_model fault_pin_osc_model_inst (
      .clk_i (clk_i),
      .run_i (run),
      .oe_i  (oe),
      .osc_o (osc),
      .pin_o (pin)
   );

   initial
   begin
      forever #5 clk_i = ~clk_i;
   end

   // instruction ticks seen at the pin, cleared by the sequence
   always @(posedge osc)
      ticks++;

   // hang guard, about half again the expected run
   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 90000)
      begin
         fail_count++;
         close_out;
      end
   end

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask

   // one-cycle strobe, taken at the second edge
   task automatic wr(input logic [7:0] d);
      @(posedge clk_i);
      svc_wr    <= 1'b1;
      svc_wdata <= d;
      @(posedge clk_i);
      svc_wr    <= 1'b0;
   endtask

   task automatic wait_oe(input logic v, input int lim);
      int n;
      n = 0;
      while (oe !== v && n < lim)
      begin
         @(posedge clk_i);
         #1;
         n++;
      end
   endtask

   // flags any pull on the pin over n cycles
   task automatic watch(input int n, output logic seen_hi);
      seen_hi = 1'b0;
      repeat (n)
      begin
         @(posedge clk_i);
         #1;
         if (oe !== 1'b0)
            seen_hi = 1'b1;
      end
   endtask

   task automatic close_out;
      $display("checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   initial
   begin
      repeat (11) @(posedge clk_i);
      #1;
      chk(oe, 1'b0);
      chk(rdata, 8'h00);
      @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1;
      chk(rdata, 8'hc1);
      chk(oe, 1'b0);
      chk(pin_d, 1'b0);
      // bad key on the very first service, then a keyed write in the fault
      wr(8'h1b);
      wait_oe(1'b1, 10);
      chk(oe, 1'b1);
      wr(8'hd8);
      wait_oe(1'b0, 400);
      chk(rdata, 8'hc1);
      // wait for the resynced pin so the next write meets the run state
      repeat (4) @(posedge clk_i);
      // first keyed write, early on purpose: window 8k, monitor on
      wr(8'h19);
      repeat (2) @(posedge clk_i);
      #1;
      chk(rdata, 8'h01);
      watch(20, hi);
      chk(hi, 1'b0);
      ticks = 0;
      wait (ticks >= 2100);
      // bit 0 differs but is not compared later
      wr(8'h18);
      watch(20, hi);
      chk(hi, 1'b0);
      chk(rdata, 8'h01);
      // back to back service lands inside the lower limit
      wr(8'h19);
      wait_oe(1'b1, 10);
      chk(oe, 1'b1);
      chk(pin_d, 1'b0);
      ticks = 0;
      wr(8'hd9);
      wait_oe(1'b0, 400);
      chk(ticks >= 16 && ticks <= 32, 1'b1);
      chk(rdata, 8'h01);
      // no service at all: upper limit of 8k ticks from restart
      ticks = 0;
      wait_oe(1'b1, 40000);
      chk(ticks >= 8190 && ticks <= 8194, 1'b1);
      wait_oe(1'b0, 400);
      // key mismatch, then window mismatch, both in window
      foreach (bad[i])
      begin
         ticks = 0;
         wait (ticks >= 2100);
         wr(bad[i]);
         wait_oe(1'b1, 10);
         chk(oe, 1'b1);
         wait_oe(1'b0, 400);
      end
      // dead oscillator holds the pin until the clock returns
      @(posedge clk_i);
      run <= 1'b0;
      wait_oe(1'b1, 400);
      chk(oe, 1'b1);
      repeat (300) @(posedge clk_i);
      #1;
      chk(oe, 1'b1);
      @(posedge clk_i);
      run <= 1'b1;
      wait_oe(1'b0, 400);
      chk(oe, 1'b0);
      // let the pin resync first, else the write dies in the wait state
      repeat (4) @(posedge clk_i);
      // disabled supervisor and stop mode ignore a bad write
      @(posedge clk_i);
      cfg <= 8'h04;
      wr(8'h00);
      watch(20, hi);
      chk(hi, 1'b0);
      @(posedge clk_i);
      cfg       <= 8'h00;
      stop_mode <= 1'b1;
      wr(8'h00);
      watch(20, hi);
      chk(hi, 1'b0);
      @(posedge clk_i);
      stop_mode <= 1'b0;
      rst_i     <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      // second life: monitor switched off on the first service
      wr(8'hd8);
      repeat (2) @(posedge clk_i);
      #1;
      chk(rdata, 8'hc0);
      @(posedge clk_i);
      run <= 1'b0;
      watch(400, hi);
      chk(hi, 1'b0);
      close_out;
   end
endmodule
`default_nettype wire
